// >>> hw/exception_trap_interrupt_unit.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
// Notes on behaviour
// - Hardware pushes pc and status word
// - Exception number indexes dispatch table
// - NMI vector 1, discarded ack read
// - Maskable needs both mask bits set
// - EI/DI touch only local mask
// - Maskable ack read yields vector 0-255
// - Emulator interrupt vector 15, ack read
// - Exception instruction selects trap type
// - Undefined, reserved, user LPR trap
// - Address beyond 16M-1 traps
// - Wrap either direction traps too
// - External illegal address input traps
// - Trace trap when pending bit set
// - Breakpoint or break line raises debug
// - Optional observability ack cycles
// - Return restores status word and pc
// - Stack pointer minus 6, frame layout
// - Entry size selects stride 4 or 2
// - Interrupts between instructions, undefined and exception traps suspend
// - Handler pc bit 0 forced zero
module exception_trap_interrupt_unit (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          srst,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Core boundary interface
  input  wire exc_pkg::step_s step,
  output logic               holdCore,
  output logic               pcLoad,
  output logic      [23:0]   pcLoadValue,
  output logic      [15:0]   processorStatusWord,
  // Interrupt requests
  input  wire logic          irqReq,
  input  wire logic          nmiReq,
  input  wire logic          emulatorIrq,
  // System bus master
  output exc_pkg::mem_s      mem,
  input  wire logic          memAck,
  input  wire logic [15:0]   memRdata
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    exc_pkg::state_e state;       // Sequencer state
    logic [15:0]     psw;         // Processor status word
    logic [23:0]     interrupt_stack_pointer;         // Interrupt stack pointer
    logic [23:0]     base;        // Dispatch table base
    logic            edBit;       // Wide dispatch entries
    logic [2:0]      dbgCtl;      // Debug control bits
    logic            busy;        // Holds the core
    exc_pkg::mem_s   mem;         // Bus request
    logic            pcLoad;      // New pc strobe
    logic [23:0]     pcVal;       // New pc value
    logic [15:0]     savedPsw;    // Status word being pushed
    logic [23:0]     savedPc;     // Pc being pushed or popped
    logic [7:0]      vec;         // Dispatch index
    logic            ackEn;       // Acknowledge cycle wanted
    logic [23:0]     ackAddr;     // Its address
    logic            irqVec;      // Vector from acknowledge byte
    logic            clearI;      // Clear global mask on entry
    logic [15:0]     entryLo;     // Low word of wide entry
    logic            nmiPend;     // Latched non-maskable edge
    logic            nmiPrev;     // Previous nmiReq level
    logic [7:0]      lastVec;     // Last vector dispatched
    logic [31:0]     prdata;      // APB read data
    logic            pready;      // APB ready
    logic            pslverr;     // APB error
  } st_s;

  st_s           r;               // Registered state
  st_s           n;               // Next state
  exc_pkg::sel_s sel;             // Priority decision

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Bus read request
  function automatic exc_pkg::mem_s rdReq(input logic [23:0] a, input logic b);
    exc_pkg::mem_s m;
    m        = '0;
    m.req    = 1'b1;
    m.byteRd = b;
    m.addr   = a;
    return m;
  endfunction

  // Bus write request
  function automatic exc_pkg::mem_s wrReq(input logic [23:0] a, input logic [15:0] d);
    exc_pkg::mem_s m;
    m       = '0;
    m.req   = 1'b1;
    m.write = 1'b1;
    m.addr  = a;
    m.wdata = d;
    return m;
  endfunction

  // Dispatch entry address
  function automatic logic [23:0] entryAddr(input logic [23:0] b, input logic [7:0] v,
                                            input logic ed);
    return ed ? b + {14'h0000, v, 2'b00}
              : b + {15'h0000, v, 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Priority selector

  exc_select u_select (
    .step    (step),
    .psw     (r.psw),
    .dbgCtl  (r.dbgCtl),
    .irqReq  (irqReq),
    .nmiPend (r.nmiPend),
    .emuReq  (emulatorIrq),
    .sel     (sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n         = r;
    n.pcLoad  = 1'b0;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    n.nmiPrev = nmiReq;

    // Sequencer
    case (r.state)
      exc_pkg::ST_IDLE: begin
        // Only accepted between instructions while not busy
        if (step.valid && !r.busy) begin
          if (sel.take) begin
            n.busy     = 1'b1;
            n.savedPc  = sel.suspend ? step.curPc : step.nextPc;
            n.savedPsw = r.psw;
            if (sel.trace_trap) begin
              n.savedPsw[exc_pkg::BIT_P] = 1'b0;
            end
            if (sel.nmi) begin
              n.nmiPend = 1'b0;
            end
            n.vec     = sel.vec;
            n.ackEn   = sel.ackEn;
            n.ackAddr = sel.ackAddr;
            n.irqVec  = sel.irqVec;
            n.clearI  = sel.clearI;
            n.interrupt_stack_pointer     = r.interrupt_stack_pointer - exc_pkg::FRAME;
            n.mem     = wrReq(n.interrupt_stack_pointer + exc_pkg::OFS_PSW, n.savedPsw);
            n.state   = exc_pkg::ST_PUSH_PSW;
          end else if (step.return_from_exception_instr) begin
            // Pop the frame
            n.busy  = 1'b1;
            n.mem   = rdReq(r.interrupt_stack_pointer + exc_pkg::OFS_PCL, 1'b0);
            n.state = exc_pkg::ST_POP_PCL;
          end else begin
            // Normal completion
            n.psw[exc_pkg::BIT_P] = r.psw[exc_pkg::BIT_T];
            if (step.ei) begin
              n.psw[exc_pkg::BIT_E] = 1'b1;
            end else if (step.di) begin
              n.psw[exc_pkg::BIT_E] = 1'b0;
            end
          end
        end
      end
      exc_pkg::ST_PUSH_PSW: begin
        if (memAck) begin
          n.mem   = wrReq(r.interrupt_stack_pointer + exc_pkg::OFS_PCL, r.savedPc[15:0]);
          n.state = exc_pkg::ST_PUSH_PCL;
        end
      end
      exc_pkg::ST_PUSH_PCL: begin
        if (memAck) begin
          n.mem   = wrReq(r.interrupt_stack_pointer + exc_pkg::OFS_PCH, {8'h00, r.savedPc[23:16]});
          n.state = exc_pkg::ST_PUSH_PCH;
        end
      end
      exc_pkg::ST_PUSH_PCH: begin
        if (memAck) begin
          // Adjust status word for the handler
          n.psw[exc_pkg::BIT_P] = 1'b0;
          n.psw[exc_pkg::BIT_T] = 1'b0;
          n.psw[exc_pkg::BIT_U] = 1'b0;
          if (r.clearI) begin
            n.psw[exc_pkg::BIT_I] = 1'b0;
          end
          if (r.ackEn) begin
            n.mem   = rdReq(r.ackAddr, 1'b1);
            n.state = exc_pkg::ST_ACK;
          end else begin
            n.mem   = rdReq(entryAddr(r.base, r.vec, r.edBit), 1'b0);
            n.state = exc_pkg::ST_ENT_LO;
          end
        end
      end
      exc_pkg::ST_ACK: begin
        if (memAck) begin
          // Byte kept only for maskable interrupts
          if (r.irqVec) begin
            n.vec = memRdata[7:0];
          end
          n.mem   = rdReq(entryAddr(r.base, n.vec, r.edBit), 1'b0);
          n.state = exc_pkg::ST_ENT_LO;
        end
      end
      exc_pkg::ST_ENT_LO: begin
        if (memAck) begin
          n.entryLo = memRdata;
          if (r.edBit) begin
            n.mem   = rdReq(r.mem.addr + exc_pkg::OFS_EHI, 1'b0);
            n.state = exc_pkg::ST_ENT_HI;
          end else begin
            n.mem     = '0;
            n.busy    = 1'b0;
            n.pcLoad  = 1'b1;
            n.pcVal   = {7'h00, memRdata, 1'b0};
            n.lastVec = r.vec;
            n.state   = exc_pkg::ST_IDLE;
          end
        end
      end
      exc_pkg::ST_ENT_HI: begin
        if (memAck) begin
          n.mem     = '0;
          n.busy    = 1'b0;
          n.pcLoad  = 1'b1;
          n.pcVal   = {memRdata[6:0], r.entryLo, 1'b0};
          n.lastVec = r.vec;
          n.state   = exc_pkg::ST_IDLE;
        end
      end
      exc_pkg::ST_POP_PCL: begin
        if (memAck) begin
          n.savedPc[15:0] = memRdata;
          n.mem   = rdReq(r.interrupt_stack_pointer + exc_pkg::OFS_PCH, 1'b0);
          n.state = exc_pkg::ST_POP_PCH;
        end
      end
      exc_pkg::ST_POP_PCH: begin
        if (memAck) begin
          n.savedPc[23:16] = memRdata[7:0];
          n.mem   = rdReq(r.interrupt_stack_pointer + exc_pkg::OFS_PSW, 1'b0);
          n.state = exc_pkg::ST_POP_PSW;
        end
      end
      exc_pkg::ST_POP_PSW: begin
        if (memAck) begin
          n.psw    = memRdata;
          n.interrupt_stack_pointer    = r.interrupt_stack_pointer + exc_pkg::FRAME;
          n.mem    = '0;
          n.busy   = 1'b0;
          n.pcLoad = 1'b1;
          n.pcVal  = r.savedPc;
          n.state  = exc_pkg::ST_IDLE;
        end
      end
      default: begin
        n.state = exc_pkg::ST_IDLE;
        n.busy  = 1'b0;
        n.mem   = '0;
      end
    endcase

    // Non-maskable edge latch, set wins over consume
    if (nmiReq && !r.nmiPrev) begin
      n.nmiPend = 1'b1;
    end

    // APB access phase, answered one cycle later
    if (psel && penable && !r.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h00000000;
      case (paddr)
        exc_pkg::REG_PSW: begin
          n.prdata = {16'h0000, r.psw};
          if (pwrite && !r.busy) begin
            n.psw = pwdata[15:0];
          end
        end
        exc_pkg::REG_ISP: begin
          n.prdata = {8'h00, r.interrupt_stack_pointer};
          if (pwrite && !r.busy) begin
            n.interrupt_stack_pointer = pwdata[23:0];
          end
        end
        exc_pkg::REG_BASE: begin
          n.prdata = {8'h00, r.base};
          if (pwrite) begin
            n.base = pwdata[23:0];
          end
        end
        exc_pkg::REG_CFG: begin
          n.prdata = {31'h00000000, r.edBit};
          if (pwrite) begin
            n.edBit = pwdata[exc_pkg::BIT_ED];
          end
        end
        exc_pkg::REG_DBG: begin
          n.prdata = {29'h00000000, r.dbgCtl};
          if (pwrite) begin
            n.dbgCtl = pwdata[2:0];
          end
        end
        exc_pkg::REG_STAT: begin
          n.prdata = {18'h00000, r.nmiPend, r.busy, 4'(r.state), r.lastVec};
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk) begin
    if (srst) begin
      r       <= '0;
      r.state <= exc_pkg::ST_IDLE;
      r.psw   <= exc_pkg::PSW_RST;
      r.interrupt_stack_pointer   <= exc_pkg::ISP_RST;
      r.base  <= exc_pkg::BASE_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops

  assign prdata              = r.prdata;
  assign pready              = r.pready;
  assign pslverr             = r.pslverr;
  assign holdCore            = r.busy;
  assign pcLoad              = r.pcLoad;
  assign pcLoadValue         = r.pcVal;
  assign processorStatusWord = r.psw;
  assign mem                 = r.mem;

endmodule

// >>> hw/exc_pkg.sv
package exc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Status word layout
  localparam int BIT_T = 1;                  // Trace enable
  localparam int BIT_U = 8;                  // User mode
  localparam int BIT_E = 9;                  // Local maskable interrupt mask
  localparam int BIT_P = 10;                 // Trace pending
  localparam int BIT_I = 11;                 // Global maskable interrupt mask

  ////////////////////////////////////////////////////////////////////////////
  // Exception numbers (dispatch table indices)
  localparam logic [7:0] VEC_NMI = 8'h01;
  localparam logic [7:0] VEC_SVC = 8'h05;
  localparam logic [7:0] VEC_DVZ = 8'h06;
  localparam logic [7:0] VEC_FLG = 8'h07;
  localparam logic [7:0] VEC_BPT = 8'h08;
  localparam logic [7:0] VEC_TRC = 8'h09;
  localparam logic [7:0] VEC_UND = 8'h0a;
  localparam logic [7:0] VEC_IAD = 8'h0c;
  localparam logic [7:0] VEC_DBG = 8'h0e;
  localparam logic [7:0] VEC_ISE = 8'h0f;

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge cycle addresses
  localparam logic [23:0] ACK_INT = 24'hfffe00;
  localparam logic [23:0] ACK_NMI = 24'hffff00;
  localparam logic [23:0] ACK_ISE = 24'hfffc00;
  localparam logic [23:0] ACK_DBG = 24'hfffc02;
  localparam logic [23:0] ACK_TRC = 24'hfffc0c;
  localparam logic [23:0] ACK_BPT = 24'hfffc0e;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt stack frame
  localparam logic [23:0] FRAME   = 24'h000006;  // Bytes per frame
  localparam logic [23:0] OFS_PCL = 24'h000000;  // Low half of saved pc
  localparam logic [23:0] OFS_PCH = 24'h000002;  // High half of saved pc
  localparam logic [23:0] OFS_PSW = 24'h000004;  // Saved status word
  localparam logic [23:0] OFS_EHI = 24'h000002;  // Upper word of wide entry

  ////////////////////////////////////////////////////////////////////////////
  // APB register map, byte addresses
  localparam logic [11:0] REG_PSW  = 12'h000;
  localparam logic [11:0] REG_ISP  = 12'h004;
  localparam logic [11:0] REG_BASE = 12'h008;
  localparam logic [11:0] REG_CFG  = 12'h00c;
  localparam logic [11:0] REG_DBG  = 12'h010;
  localparam logic [11:0] REG_STAT = 12'h014;
  localparam int BIT_ED   = 0;               // Config: wide dispatch entries
  localparam int BIT_DEBUG_ACK_CYCLE_ENABLE = 0;               // Debug ctl: ack on debug trap
  localparam int BIT_TRACE_ACK_CYCLE_ENABLE = 1;               // Debug ctl: ack on trace trap
  localparam int BIT_BREAKPOINT_ACK_CYCLE_ENABLE = 2;               // Debug ctl: ack on breakpoint

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [15:0] PSW_RST  = 16'h0000;
  localparam logic [23:0] ISP_RST  = 24'h000000;
  localparam logic [23:0] BASE_RST = 24'h000000;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_PUSH_PSW, ST_PUSH_PCL, ST_PUSH_PCH, ST_ACK,
    ST_ENT_LO, ST_ENT_HI, ST_POP_PCL, ST_POP_PCH, ST_POP_PSW
  } state_e;

  // One instruction boundary reported by the core
  typedef struct packed {
    logic        valid;      // Boundary strobe
    logic [23:0] curPc;      // Address of this instruction
    logic [23:0] nextPc;     // Address of the following one
    logic        undef;      // Undefined opcode
    logic        lpr;        // Load-processor-register instruction
    logic        raise_exception_instr;       // Raise-exception instruction
    logic [3:0]  excpCode;   // Its trap number field
    logic        return_from_exception_instr;       // Return-from-exception instruction
    logic        ei;         // Enable-interrupts instruction
    logic        di;         // Disable-interrupts instruction
    logic        addrChk;    // genAddr carries a generated address
    logic [25:0] genAddr;    // Address with carry and borrow bits
    logic        extIllegal; // External illegal address input
    logic        bkptHit;    // Breakpoint module hit
    logic        extBreak;   // External break line tag
  } step_s;

  // Memory request to the system bus
  typedef struct packed {
    logic        req;
    logic        write;
    logic        byteRd;     // Byte read, used by acknowledge cycles
    logic [23:0] addr;
    logic [15:0] wdata;
  } mem_s;

  // Decision from the priority selector
  typedef struct packed {
    logic        take;       // An exception is taken
    logic        suspend;    // Save current pc instead of next
    logic        clearI;     // Also clear the global mask
    logic        trace_trap;        // Trace trap, clear pending bit first
    logic        nmi;        // Non-maskable interrupt consumed
    logic        ackEn;      // Run an acknowledge cycle
    logic [23:0] ackAddr;
    logic        irqVec;     // Vector comes from acknowledge byte
    logic [7:0]  vec;
  } sel_s;

endpackage

// >>> hw/exc_select.sv
`timescale 1ns/100ps
// Fixed priority choice among pending exceptions at one boundary
module exc_select (
  // Boundary and context
  input  wire exc_pkg::step_s step,
  input  wire logic [15:0]    psw,
  input  wire logic [2:0]     dbgCtl,
  // Interrupt requests
  input  wire logic           irqReq,
  input  wire logic           nmiPend,
  input  wire logic           emuReq,
  // Decision
  output exc_pkg::sel_s       sel
);

  logic illegal;   // Address fault
  logic undefOp;   // Undefined-op conditions
  logic excpOk;    // Exception instruction with a valid number
  logic maskOk;    // Maskable interrupts open

  // Classify the boundary
  always_comb begin
    illegal = (step.addrChk & (step.genAddr[25:24] != 2'b00))
            | step.extIllegal;
    excpOk  = step.raise_exception_instr & ({4'h0, step.excpCode} == exc_pkg::VEC_SVC
            || {4'h0, step.excpCode} == exc_pkg::VEC_DVZ
            || {4'h0, step.excpCode} == exc_pkg::VEC_FLG
            || {4'h0, step.excpCode} == exc_pkg::VEC_BPT);
    undefOp = step.undef
            | (step.lpr & psw[exc_pkg::BIT_U])
            | (step.raise_exception_instr & ~excpOk);
    maskOk  = psw[exc_pkg::BIT_E] & psw[exc_pkg::BIT_I];
  end

  // Priority: traps, then emulator, non-maskable, maskable
  always_comb begin
    sel = '0;
    sel.take = 1'b1;
    if (illegal) begin
      sel.vec = exc_pkg::VEC_IAD;
    end else if (undefOp) begin
      sel.vec     = exc_pkg::VEC_UND;
      sel.suspend = 1'b1;
    end else if (excpOk) begin
      sel.vec     = {4'h0, step.excpCode};
      sel.suspend = 1'b1;
      sel.ackEn   = (sel.vec == exc_pkg::VEC_BPT) & dbgCtl[exc_pkg::BIT_BREAKPOINT_ACK_CYCLE_ENABLE];
      sel.ackAddr = exc_pkg::ACK_BPT;
    end else if (step.bkptHit | step.extBreak) begin
      sel.vec     = exc_pkg::VEC_DBG;
      sel.clearI  = 1'b1;
      sel.ackEn   = dbgCtl[exc_pkg::BIT_DEBUG_ACK_CYCLE_ENABLE];
      sel.ackAddr = exc_pkg::ACK_DBG;
    end else if (psw[exc_pkg::BIT_P]) begin
      sel.vec     = exc_pkg::VEC_TRC;
      sel.trace_trap     = 1'b1;
      sel.ackEn   = dbgCtl[exc_pkg::BIT_TRACE_ACK_CYCLE_ENABLE];
      sel.ackAddr = exc_pkg::ACK_TRC;
    end else if (emuReq) begin
      sel.vec     = exc_pkg::VEC_ISE;
      sel.clearI  = 1'b1;
      sel.ackEn   = 1'b1;
      sel.ackAddr = exc_pkg::ACK_ISE;
    end else if (nmiPend) begin
      sel.vec     = exc_pkg::VEC_NMI;
      sel.nmi     = 1'b1;
      sel.clearI  = 1'b1;
      sel.ackEn   = 1'b1;
      sel.ackAddr = exc_pkg::ACK_NMI;
    end else if (irqReq & maskOk) begin
      sel.clearI  = 1'b1;
      sel.ackEn   = 1'b1;
      sel.irqVec  = 1'b1;
      sel.ackAddr = exc_pkg::ACK_INT;
    end else begin
      sel.take = 1'b0;
    end
  end

endmodule

// >>> sim/exc_unit_properties.sv
`timescale 1ns/100ps
// Port-level checks of the exception unit
module exc_unit_checker (
  // Clock and reset
  input wire logic           clk,
  input wire logic           srst,
  // Core side
  input wire exc_pkg::step_s step,
  input wire logic           holdCore,
  input wire logic           pcLoad,
  input wire logic [23:0]    pcLoadValue,
  input wire logic [15:0]    processorStatusWord,
  input wire logic           irqReq,
  input wire logic           nmiReq,
  input wire logic           emulatorIrq,
  // System bus
  input wire exc_pkg::mem_s  mem,
  input wire logic           memAck
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic quiet;  // Boundary with no cause other than a maskable request
  logic open;   // Both maskable mask bits set
  assign quiet = !(step.undef | step.lpr | step.raise_exception_instr | step.return_from_exception_instr | step.addrChk | step.extIllegal
    | step.bkptHit | step.extBreak | nmiReq | emulatorIrq | processorStatusWord[exc_pkg::BIT_P]);
  assign open = processorStatusWord[exc_pkg::BIT_E] & processorStatusWord[exc_pkg::BIT_I];
  ld_bit0_a: assert property (pcLoad |-> !pcLoadValue[0])
    else $error("odd handler pc");
  ld_release_a: assert property (pcLoad |-> !holdCore && $past(holdCore) && !mem.req)
    else $error("load outside sequence");
  psw_push_a: assert property (step.valid && !holdCore && (step.undef || step.raise_exception_instr)
    |=> mem.req && mem.write && mem.wdata == $past(processorStatusWord)) else $error("bad push");
  irq_masked_a: assert property (step.valid && !holdCore && quiet && !open |=> !holdCore)
    else $error("masked irq taken");
  irq_taken_a: assert property (step.valid && !holdCore && quiet && irqReq && open
    |=> ##[1:60] mem.req && mem.byteRd && mem.addr == exc_pkg::ACK_INT) else $error("no irq ack");
  mem_hold_a: assert property (mem.req && !memAck |=> mem.req && $stable(mem.addr))
    else $error("request dropped");
  ack_addr_a: assert property (mem.req && mem.byteRd |-> !mem.write && mem.addr[23:8] >= 16'hfffc)
    else $error("bad ack cycle");
  nmi_entry_a: assert property (memAck && mem.byteRd && mem.addr == exc_pkg::ACK_NMI
    |=> mem.req && !mem.byteRd && !mem.write) else $error("no entry read");
  cover property (pcLoad);
  cover property (mem.req && mem.addr == exc_pkg::ACK_INT);
  cover property (mem.req && mem.addr == exc_pkg::ACK_DBG);
endmodule

bind exception_trap_interrupt_unit exc_unit_checker chk_u (.clk, .srst, .step, .holdCore,
  .pcLoad, .pcLoadValue, .processorStatusWord, .irqReq, .nmiReq, .emulatorIrq, .mem, .memAck);

// >>> sim/sys_bus_model.sv
`timescale 1ns/100ps
// Word memory plus interrupt controller on the system bus
module sys_bus_model (
  // Clock and reset
  input wire logic          clk,
  input wire logic          srst,
  // Bus
  input wire exc_pkg::mem_s mem,
  output logic              memAck,
  output logic [15:0]       memRdata,
  // Bench controls
  input wire logic [7:0]    irqVec,
  input wire logic [3:0]    lag
);
  logic [15:0] ram [0:511];  // Stack and dispatch table
  logic [3:0]  waitCnt;      // Cycles a request has waited
  initial begin
    memRdata = 16'ha5a5;
    for (int i = 0; i < 512; i++) ram[i] = 16'h1000 + 16'(i);
  end
  // Answer after lag cycles; data toggles while idle
  always @(posedge clk) begin
    if (srst || !mem.req || memAck) begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
      memRdata <= ~memRdata;
    end else if (waitCnt < lag) begin
      waitCnt <= waitCnt + 4'h1;
      memRdata <= ~memRdata;
    end else begin
      memAck <= 1'b1;
      if (mem.write) ram[mem.addr[9:1]] <= mem.wdata;
      if (!mem.byteRd) memRdata <= ram[mem.addr[9:1]];
      else if (mem.addr == exc_pkg::ACK_INT) memRdata <= {8'h00, irqVec};
      else memRdata <= {8'h00, ~irqVec};
    end
  end
endmodule

// >>> sim/tb.sv
`timescale 1ns/100ps
// Exception unit bench
module tb;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, holdCore, pcLoad, memAck, ed = 1'b0;
  logic irqReq = 1'b0, nmiReq = 1'b0, emulatorIrq = 1'b0;
  logic [23:0] pcLoadValue;
  logic [15:0] psw, memRdata;
  logic [7:0] irqVec = 8'h20;
  logic [3:0] lag = 4'h0;
  exc_pkg::step_s st = '0, s;
  exc_pkg::step_s b = '{valid: 1'b1, curPc: 24'h2000, nextPc: 24'h2002, default: '0};
  exc_pkg::mem_s mem;
  int miscompares = 0, checked = 0;
  always #10 clk = ~clk;
  exception_trap_interrupt_unit dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .step(st), .holdCore(holdCore), .pcLoad(pcLoad),
    .pcLoadValue(pcLoadValue), .processorStatusWord(psw), .irqReq(irqReq), .nmiReq(nmiReq),
    .emulatorIrq(emulatorIrq), .mem(mem), .memAck(memAck), .memRdata(memRdata));
  sys_bus_model bus_u (.clk(clk), .srst(srst), .mem(mem), .memAck(memAck),
    .memRdata(memRdata), .irqVec(irqVec), .lag(lag));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer, read data kept in rd
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One boundary strobe, then the edge after it is taken
  task automatic bnd(input exc_pkg::step_s x);
    @(posedge clk);
    st <= x;
    @(posedge clk);
    st <= '0;
    @(posedge clk);
  endtask
  task automatic run(input exc_pkg::step_s x, input logic [23:0] interrupt_stack_pointer, input logic [23:0] pc);
    int n = 0;
    apb(1'b1, exc_pkg::REG_ISP, {8'h00, interrupt_stack_pointer});
    bnd(x);
    do @(posedge clk); while (pcLoad !== 1'b1 && ++n < 300);
    chk("handler pc", {8'h00, pc}, {8'h00, pcLoadValue});
  endtask
  // Handler address the model's table holds for a vector
  function automatic logic [23:0] hnd(input logic [7:0] v);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = ed ? 16'h1000 + {7'h00, v, 1'b0} : 16'h1000 + {8'h00, v};
    hi = lo + 16'h0001;
    return ed ? {hi[6:0], lo, 1'b0} : {7'h00, lo, 1'b0};
  endfunction
  task automatic tend(input string n);
    $display("test %s done", n);
  endtask
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, exc_pkg::REG_CFG, 32'h0);
    chk("cfg", 32'h0, rd);
    apb(1'b1, exc_pkg::REG_ISP, 32'h400);
    apb(1'b0, exc_pkg::REG_ISP, 32'h0);
    chk("isp", 32'h400, rd);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, exc_pkg::REG_PSW, 32'hb00);
    s = b;
    s.lpr = 1'b1;
    run(s, 24'h400, hnd(exc_pkg::VEC_UND));
    chk("saved pc", 32'h2000, {16'h0, bus_u.ram[9'h1fd]});
    chk("saved psw", 32'hb00, {16'h0, bus_u.ram[9'h1ff]});
    chk("trap psw", 32'ha00, {16'h0, psw});
    s = b;
    s.return_from_exception_instr = 1'b1;
    run(s, 24'h3fa, 24'h002000);
    chk("restored psw", 32'hb00, {16'h0, psw});
    apb(1'b1, exc_pkg::REG_PSW, 32'h0);
    for (int i = 3; i < 11; i++) begin
      s = b;
      s.raise_exception_instr = 1'b1;
      s.excpCode = i[3:0];
      run(s, 24'h400, hnd((i > 4 && i < 9) ? i[7:0] : exc_pkg::VEC_UND));
    end
    tend("traps");
    apb(1'b1, exc_pkg::REG_PSW, 32'h800);
    irqReq <= 1'b1;
    lag <= 4'h3;
    bnd(b);
    chk("masked", 32'h0, {31'h0, holdCore});
    s = b;
    s.ei = 1'b1;
    bnd(s);
    chk("ei", 32'ha00, {16'h0, psw});
    run(b, 24'h400, hnd(8'h20));
    chk("next pc", 32'h2002, {16'h0, bus_u.ram[9'h1fd]});
    chk("irq psw", 32'h200, {16'h0, psw});
    irqReq <= 1'b0;
    apb(1'b1, exc_pkg::REG_PSW, 32'ha00);
    s = b;
    s.di = 1'b1;
    bnd(s);
    chk("di", 32'h800, {16'h0, psw});
    apb(1'b1, exc_pkg::REG_CFG, 32'h1);
    ed = 1'b1;
    nmiReq <= 1'b1;
    emulatorIrq <= 1'b1;
    run(b, 24'h400, hnd(exc_pkg::VEC_ISE));
    emulatorIrq <= 1'b0;
    run(b, 24'h400, hnd(exc_pkg::VEC_NMI));
    nmiReq <= 1'b0;
    tend("interrupts");
    s = b;
    s.addrChk = 1'b1;
    s.genAddr = 26'h0ffffff;
    bnd(s);
    chk("legal addr", 32'h0, {31'h0, holdCore});
    s.genAddr = 26'h1000000;
    run(s, 24'h400, hnd(exc_pkg::VEC_IAD));
    s.genAddr = 26'h3fffffe;
    run(s, 24'h400, hnd(exc_pkg::VEC_IAD));
    s = b;
    s.extIllegal = 1'b1;
    run(s, 24'h400, hnd(exc_pkg::VEC_IAD));
    apb(1'b1, exc_pkg::REG_DBG, 32'h7);
    s = b;
    s.bkptHit = 1'b1;
    run(s, 24'h400, hnd(exc_pkg::VEC_DBG));
    s = b;
    s.extBreak = 1'b1;
    run(s, 24'h400, hnd(exc_pkg::VEC_DBG));
    apb(1'b1, exc_pkg::REG_PSW, 32'h400);
    run(b, 24'h400, hnd(exc_pkg::VEC_TRC));
    chk("trace psw", 32'h0, {16'h0, bus_u.ram[9'h1ff]});
    tend("address and debug");
    summarize();
  end
endmodule
